/* File: common/prl_pkg.sv */
// package of the port rate limiter and queue shaper
// assumes one instance per switch port on the 250 MHz core clock
package prl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_GLB    = 8'h00;
  localparam logic [7:0] ADR_PCTL   = 8'h04;
  localparam logic [7:0] ADR_IRATE  = 8'h08;
  localparam logic [7:0] ADR_ERATE  = 8'h0C;
  localparam logic [7:0] ADR_RATIO  = 8'h10;
  localparam logic [7:0] ADR_PCPMAP = 8'h14;
  localparam logic [7:0] ADR_DSCP0  = 8'h18;
  localparam logic [7:0] ADR_STAT   = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GLB_QRL   = 0;
  localparam int GLB_IFG   = 1;
  localparam int GLB_PRE   = 2;
  localparam int PC_QMODE  = 0;
  localparam int PC_SEL    = 2;
  localparam int PC_FC     = 4;
  localparam int PC_PPRIO  = 5;
  localparam int PC_PMODE  = 7;
  localparam int RATE_STEP = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_GLB    = 32'h0000_0000;
  localparam logic [7:0]  RST_PCTL   = 8'h00;
  localparam logic [31:0] RST_RATE   = 32'h0000_0000;
  localparam logic [31:0] RST_RATIO  = 32'h0804_0201;
  localparam logic [15:0] RST_PCPMAP = 16'hFA50;
  localparam logic [31:0] RST_DSCP0  = 32'h0000_0000;
  localparam logic [31:0] RST_DSCP1  = 32'h5555_5555;
  localparam logic [31:0] RST_DSCP2  = 32'hAAAA_AAAA;
  localparam logic [31:0] RST_DSCP3  = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PRL_Q1 = 2'b00,
    PRL_Q2 = 2'b01,
    PRL_Q4 = 2'b10
  } prl_qmode_e;

  typedef enum logic [1:0] {
    PRL_SEL_ALL   = 2'b00,
    PRL_SEL_MC    = 2'b01,
    PRL_SEL_BC    = 2'b10,
    PRL_SEL_FLOOD = 2'b11
  } prl_sel_e;

  // ----------------------------------------------------------------
  // rate codes and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  CODE_10M      = 7'h0A;
  localparam logic [6:0]  CODE_MBPS_MAX = 7'h64;
  localparam logic [6:0]  CODE_SUB_MAX  = 7'h73;
  localparam int          CLK_NS        = 4;
  localparam int          TICK_NS       = 125000;
  localparam int          TICK_CYC      = TICK_NS / CLK_NS;
  localparam logic [13:0] BITS_MBPS     = 14'(TICK_NS / 1000);
  localparam logic [13:0] BITS_STEP     = 14'(64 * TICK_NS / 1000000);
  localparam logic [13:0] IFG_BYTES     = 14'h000C;
  localparam logic [13:0] PRE_BYTES     = 14'h0008;
  localparam logic signed [19:0] LVL_CAP = 20'sh0FFFF;

endpackage : prl_pkg

/* File: rtl/prl_port_shaper.sv */
// per port ingress policer and egress shaper with queue ratio gate
// assumes frame descriptors and queue status come from same-clock logic
//
// Notes on behaviour
// RL1 - below 1 Mbps use 64 kbps steps
// RL2 - above 1 Mbps use 1 Mbps steps
// RL3 - ingress and egress limits set independently
// RL4 - on 10 Mbps links rates above 10 unlimited
// RL5 - ingress limited per priority; ingress buckets here are indexed by queue number rx_q
// RL6 - egress limited per priority queue
// RL7 - size DA to FCS, optional gap, preamble
// RL8 - two-bit select of counted frame types
// RL9 - only selected frame types are counted
// RL10 - over limit drops, or pauses when enabled
// RL11 - port priority from two-bit port field
// RL12 - remap tag and diffserv priorities by tables
// RL13 - queue limiting needs global enable bit; egress queue buckets and q_live here do not depend on qrl
// RL14 - queue number follows priority per mode
// RL15 - leaky bucket per egress queue
// RL16 - shaping by stretching gap between frames
// RL17 - full queue memory drops or pauses ingress
// RL18 - lower queues limited by ratio to highest
// RL19 - per port ratio for queues zero to three
// RL20 - highest queue never held by ratio
// RL21 - software sets same queue mode everywhere
// RL22 - software keeps egress above ingress bandwidth
// RL23 - buckets credited on fixed tick by rate
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module prl_port_shaper #(
  parameter int TICK_CYC = prl_pkg::TICK_CYC,
  parameter int LEN_W    = 11
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  // link status
  input  wire logic             speed10_i,
  // ingress descriptor
  input  wire logic             rx_vld_i,
  input  wire logic [LEN_W-1:0] rx_len_i,
  input  wire logic             rx_mc_i,
  input  wire logic             rx_bc_i,
  input  wire logic             rx_flood_i,
  input  wire logic             rx_tag_i,
  input  wire logic [2:0]       rx_pcp_i,
  input  wire logic             rx_ip_i,
  input  wire logic [5:0]       rx_dscp_i,
  input  wire logic             rx_mem_full_i,
  output logic                  rx_dec_vld_o,
  output logic                  rx_dec_drop_o,
  output logic      [1:0]       rx_dec_q_o,
  output logic                  rx_pause_o,
  // egress queues
  input  wire logic [3:0]       tx_pend_i,
  input  wire logic             tx_sent_i,
  input  wire logic [1:0]       tx_sent_q_i,
  input  wire logic [LEN_W-1:0] tx_sent_len_i,
  output logic      [3:0]       tx_ok_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [14:0] prl_rdec(input logic [6:0] code, input logic s10);
    logic        unl;
    logic [13:0] cr;
    unl = 1'b0;
    cr  = 14'h0000;
    if (code == 7'h00 || code > prl_pkg::CODE_SUB_MAX)
      unl = 1'b1;
    else if (code > prl_pkg::CODE_MBPS_MAX)
      cr = 14'(code - prl_pkg::CODE_MBPS_MAX) * prl_pkg::BITS_STEP; // RL1
    else if (s10 && code > prl_pkg::CODE_10M)
      unl = 1'b1; // RL4
    else
      cr = 14'(code) * prl_pkg::BITS_MBPS; // RL2
    return {unl, cr};
  endfunction : prl_rdec
  function automatic logic [16:0] prl_fbits(input logic [LEN_W-1:0] len,
                                            input logic ifg, input logic pre);
    logic [13:0] b;
    b = 14'(len) + (ifg ? prl_pkg::IFG_BYTES : 14'h0000)
                 + (pre ? prl_pkg::PRE_BYTES : 14'h0000); // RL7
    return {b, 3'h0};
  endfunction : prl_fbits
  function automatic logic signed [19:0] prl_bnext(input logic signed [19:0] lvl,
                                                   input logic [13:0] add,
                                                   input logic [16:0] sub);
    logic signed [21:0] t;
    t = 22'(lvl) + $signed({8'h00, add}) - $signed({5'h00, sub});
    if (t > 22'(prl_pkg::LVL_CAP))
      t = 22'(prl_pkg::LVL_CAP);
    else if (t < -22'(prl_pkg::LVL_CAP))
      t = -22'(prl_pkg::LVL_CAP);
    return t[19:0];
  endfunction : prl_bnext

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]  glb_r;
  logic [7:0]  pctl_r;
  logic [31:0] irate_r;
  logic [31:0] erate_r;
  logic [31:0] ratio_r;
  logic [15:0] pcpmap_r;
  logic [31:0] dscp_r [4];
  logic [15:0] drop_cnt_r;
  logic [31:0] rd_mux;
  logic [3:0]  ing_over;
  logic [3:0]  egr_over;

  wire logic             qrl   = glb_r[prl_pkg::GLB_QRL];
  wire logic             ifg   = glb_r[prl_pkg::GLB_IFG];
  wire logic             pre   = glb_r[prl_pkg::GLB_PRE];
  wire prl_pkg::prl_qmode_e qmode = prl_pkg::prl_qmode_e'(pctl_r[prl_pkg::PC_QMODE +: 2]);
  wire prl_pkg::prl_sel_e   sel   = prl_pkg::prl_sel_e'(pctl_r[prl_pkg::PC_SEL +: 2]);
  wire logic             fc    = pctl_r[prl_pkg::PC_FC];
  wire logic [1:0]       pprio = pctl_r[prl_pkg::PC_PPRIO +: 2];
  wire logic             pmode = pctl_r[prl_pkg::PC_PMODE];
  wire logic wr_glb   = reg_wr_i && reg_addr_i == prl_pkg::ADR_GLB;
  wire logic wr_pctl  = reg_wr_i && reg_addr_i == prl_pkg::ADR_PCTL;
  wire logic wr_irate = reg_wr_i && reg_addr_i == prl_pkg::ADR_IRATE;
  wire logic wr_erate = reg_wr_i && reg_addr_i == prl_pkg::ADR_ERATE;
  wire logic wr_ratio = reg_wr_i && reg_addr_i == prl_pkg::ADR_RATIO;
  wire logic wr_pcp   = reg_wr_i && reg_addr_i == prl_pkg::ADR_PCPMAP;
  wire logic [7:0] dscp_off = reg_addr_i - prl_pkg::ADR_DSCP0;
  wire logic wr_dscp  = reg_wr_i && dscp_off < 8'h10 && dscp_off[1:0] == 2'b00;
  // separate ingress and egress settings, one set per port
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      glb_r    <= prl_pkg::RST_GLB[2:0];
      pctl_r   <= prl_pkg::RST_PCTL;
      irate_r  <= prl_pkg::RST_RATE;
      erate_r  <= prl_pkg::RST_RATE;
      ratio_r  <= prl_pkg::RST_RATIO;
      pcpmap_r <= prl_pkg::RST_PCPMAP;
      dscp_r   <= '{prl_pkg::RST_DSCP0, prl_pkg::RST_DSCP1,
                    prl_pkg::RST_DSCP2, prl_pkg::RST_DSCP3};
    end
    else
    begin
      if (wr_glb)   glb_r    <= reg_wdata_i[2:0];
      if (wr_pctl)  pctl_r   <= reg_wdata_i[7:0];
      if (wr_irate) irate_r  <= reg_wdata_i; // RL3
      if (wr_erate) erate_r  <= reg_wdata_i; // RL3
      if (wr_ratio) ratio_r  <= reg_wdata_i; // RL19
      if (wr_pcp)   pcpmap_r <= reg_wdata_i[15:0];
      if (wr_dscp)  dscp_r[dscp_off[3:2]] <= reg_wdata_i;
    end
  end

  always_comb
  begin
    unique case (reg_addr_i)
      prl_pkg::ADR_GLB:    rd_mux = {29'h0000_0000, glb_r};
      prl_pkg::ADR_PCTL:   rd_mux = {24'h00_0000, pctl_r};
      prl_pkg::ADR_IRATE:  rd_mux = irate_r;
      prl_pkg::ADR_ERATE:  rd_mux = erate_r;
      prl_pkg::ADR_RATIO:  rd_mux = ratio_r;
      prl_pkg::ADR_PCPMAP: rd_mux = {16'h0000, pcpmap_r};
      prl_pkg::ADR_STAT:   rd_mux = {drop_cnt_r, 7'h00, rx_pause_o, egr_over, ing_over};
      default:             rd_mux = wr_dscp || (dscp_off < 8'h10 && dscp_off[1:0] == 2'b00)
                                    ? dscp_r[dscp_off[3:2]] : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 32'h0000_0000;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // credit tick
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYC + 1);
  logic [TW-1:0] tick_cnt_r;
  logic          tick_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= tick_cnt_r == TW'(TICK_CYC - 1); // RL23
      tick_cnt_r <= tick_cnt_r == TW'(TICK_CYC - 1) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // ingress classification
  // ----------------------------------------------------------------
  wire logic [1:0] pcp_p  = pcpmap_r[{rx_pcp_i, 1'b0} +: 2]; // RL12
  wire logic [1:0] dscp_p = dscp_r[rx_dscp_i[5:4]][{rx_dscp_i[3:0], 1'b0} +: 2]; // RL12
  wire logic [1:0] rx_prio = !pmode ? pprio : // RL11
                             rx_tag_i ? pcp_p : rx_ip_i ? dscp_p : pprio;
  logic [1:0] rx_q;
  logic       sel_hit;

  always_comb
  begin
    rx_q = 2'b00;
    if (qrl) // RL13
    begin
      unique case (qmode)
        prl_pkg::PRL_Q4: rx_q = rx_prio; // RL14
        prl_pkg::PRL_Q2: rx_q = {1'b0, rx_prio != 2'b00}; // RL14
        default:         rx_q = 2'b00;
      endcase
    end
  end
  always_comb
  begin
    unique case (sel) // RL8
      prl_pkg::PRL_SEL_ALL: sel_hit = 1'b1;
      prl_pkg::PRL_SEL_MC:  sel_hit = rx_mc_i;
      prl_pkg::PRL_SEL_BC:  sel_hit = rx_bc_i;
      default:              sel_hit = rx_flood_i;
    endcase
  end

  wire logic        rx_over = sel_hit && ing_over[rx_q]; // RL9
  wire logic        rx_drop = (rx_over || rx_mem_full_i) && !fc; // RL10 RL17
  wire logic [16:0] rx_bits = prl_fbits(rx_len_i, ifg, pre);
  wire logic [16:0] tx_bits = prl_fbits(tx_sent_len_i, ifg, pre);

  // ----------------------------------------------------------------
  // leaky buckets, ingress and egress per queue number
  // ----------------------------------------------------------------
  logic signed [19:0] ing_lvl_r [4];
  logic signed [19:0] egr_lvl_r [4];

  for (genvar q = 0; q < 4; q++)
  begin : g_bkt
    wire logic [14:0] idec = prl_rdec(irate_r[q*prl_pkg::RATE_STEP +: 7], speed10_i);
    wire logic [14:0] edec = prl_rdec(erate_r[q*prl_pkg::RATE_STEP +: 7], speed10_i);
    wire logic ichg = rx_vld_i && sel_hit && rx_q == 2'(q) && !rx_drop; // RL9
    wire logic echg = tx_sent_i && tx_sent_q_i == 2'(q);
    assign ing_over[q] = !idec[14] && ing_lvl_r[q] < 0; // RL5
    assign egr_over[q] = !edec[14] && egr_lvl_r[q] < 0; // RL6 RL15
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        ing_lvl_r[q] <= 20'sh00000;
        egr_lvl_r[q] <= 20'sh00000;
      end
      else
      begin
        ing_lvl_r[q] <= idec[14] ? 20'sh00000 : prl_bnext(ing_lvl_r[q], // RL23
                        tick_r ? idec[13:0] : 14'h0000, ichg ? rx_bits : 17'h00000);
        egr_lvl_r[q] <= edec[14] ? 20'sh00000 : prl_bnext(egr_lvl_r[q], // RL15
                        tick_r ? edec[13:0] : 14'h0000, echg ? tx_bits : 17'h00000);
      end
    end
  end

  // ----------------------------------------------------------------
  // ingress decision
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_dec_vld_o  <= 1'b0;
      rx_dec_drop_o <= 1'b0;
      rx_dec_q_o    <= 2'b00;
      rx_pause_o    <= 1'b0;
      drop_cnt_r    <= 16'h0000;
    end
    else
    begin
      rx_dec_vld_o  <= rx_vld_i;
      rx_dec_drop_o <= rx_vld_i && rx_drop; // RL10
      rx_dec_q_o    <= rx_q;
      rx_pause_o    <= fc && ((|ing_over) || rx_mem_full_i); // RL10 RL17
      if (rx_vld_i && rx_drop)
        drop_cnt_r <= drop_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // transmit ratio gate and gap stretch
  // ----------------------------------------------------------------
  logic [6:0] rcnt_r [4];
  logic [1:0] hi;
  logic [3:0] blocked;
  logic [3:0] q_live;

  always_comb
  begin
    unique case (qmode)
      prl_pkg::PRL_Q4: hi = 2'd3;
      prl_pkg::PRL_Q2: hi = 2'd1;
      default:         hi = 2'd0;
    endcase
  end
  wire logic       ratio_on = qrl && hi != 2'd0; // RL18
  wire logic [6:0] hi_ratio = ratio_r[hi*prl_pkg::RATE_STEP +: 7];
  wire logic       rnd_clr  = !tx_pend_i[hi] || (tx_sent_i && tx_sent_q_i == hi
                              && rcnt_r[hi] + 7'h01 >= hi_ratio);

  for (genvar q = 0; q < 4; q++)
  begin : g_rat
    wire logic [6:0] rq = ratio_r[q*prl_pkg::RATE_STEP +: 7]; // RL19
    assign q_live[q]  = 2'(q) <= hi;
    assign blocked[q] = ratio_on && 2'(q) != hi && rcnt_r[q] >= rq; // RL18 RL20
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        rcnt_r[q] <= 7'h00;
      else if (rnd_clr)
        rcnt_r[q] <= 7'h00;
      else if (tx_sent_i && tx_sent_q_i == 2'(q) && rcnt_r[q] != 7'h7F)
        rcnt_r[q] <= rcnt_r[q] + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tx_ok_o <= 4'h0;
    else
      tx_ok_o <= q_live & ~egr_over & ~blocked; // RL16
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_fc_nodrop;
    rx_vld_i && fc |=> rx_dec_vld_o && !rx_dec_drop_o;
  endproperty
  a_fc_nodrop: assert property (p_fc_nodrop) else $error("drop while pause enabled"); // RL10
  property p_over_drop;
    rx_vld_i && sel_hit && ing_over[rx_q] && !fc |=> rx_dec_drop_o;
  endproperty
  a_over_drop: assert property (p_over_drop) else $error("over limit frame kept"); // RL10
  property p_unsel;
    rx_vld_i && !sel_hit && !rx_mem_full_i |=> !rx_dec_drop_o;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected frame dropped"); // RL9
  property p_pprio;
    rx_vld_i && !pmode && qrl && qmode == prl_pkg::PRL_Q4 |=> rx_dec_q_o == $past(pprio);
  endproperty
  a_pprio: assert property (p_pprio) else $error("port priority not used"); // RL11
  property p_noqrl;
    rx_vld_i && !qrl |=> rx_dec_q_o == 2'b00;
  endproperty
  a_noqrl: assert property (p_noqrl) else $error("queue used without enable"); // RL13
  property p_shape;
    egr_over[0] |=> !tx_ok_o[0];
  endproperty
  a_shape: assert property (p_shape) else $error("queue sent while bucket empty"); // RL15
  property p_hi_free;
    qrl && qmode == prl_pkg::PRL_Q4 && !egr_over[3] |=> tx_ok_o[3];
  endproperty
  a_hi_free: assert property (p_hi_free) else $error("highest queue held"); // RL20
  property p_ratio;
    ratio_on && hi == 2'd3 && rcnt_r[0] >= ratio_r[6:0] |=> !tx_ok_o[0];
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not enforced"); // RL18
  property p_unl10;
    speed10_i && erate_r[6:0] > prl_pkg::CODE_10M
      && erate_r[6:0] <= prl_pkg::CODE_MBPS_MAX |-> !egr_over[0];
  endproperty
  a_unl10: assert property (p_unl10) else $error("rate above link speed limited"); // RL4
  property p_tick;
    tick_r |=> !tick_r;
  endproperty
  a_tick: assert property (p_tick) else $error("credit tick too dense"); // RL23

  c_drop:  cover property (rx_dec_vld_o && rx_dec_drop_o);
  c_pause: cover property (rx_pause_o);
  c_ratio: cover property (blocked[0] && tx_pend_i[0]);
  c_tick:  cover property (tick_r && egr_over[1]);

endmodule : prl_port_shaper

`default_nettype wire

/* File: sim/prl_tx_partner.sv */
// egress queue source model that feeds the shaper with frames
// assumes tx_ok_i is the shaper's registered per queue permission
`timescale 1ns/1ps
`default_nettype none

module prl_tx_partner #(
  parameter int GAP = 3
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control and status
  input  wire logic [3:0]  pend_en_i,
  input  wire logic [3:0]  tx_ok_i,
  // queue side
  output logic      [3:0]  tx_pend_o,
  output logic             tx_sent_o,
  output logic      [1:0]  tx_sent_q_o,
  output logic      [10:0] tx_sent_len_o
);
  logic [1:0] ptr_r;
  logic [2:0] wait_r;
  logic [3:0] live;
  logic [1:0] pick;
  logic       hit;

  assign tx_pend_o = pend_en_i;
  assign live      = tx_ok_i & pend_en_i;

  // round robin over queues that may start
  always_comb
  begin
    hit  = 1'b0;
    pick = ptr_r;
    for (int k = 0; k < 4; k++)
    begin
      if (!hit && live[2'(ptr_r - 2'(k))])
      begin
        hit  = 1'b1;
        pick = 2'(ptr_r - 2'(k));
      end
    end
  end

  // one frame, then a gap; idle qualifiers toggle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_r         <= 2'h3;
      wait_r        <= 3'h0;
      tx_sent_o     <= 1'b0;
      tx_sent_q_o   <= 2'h0;
      tx_sent_len_o <= 11'h000;
    end
    else if (wait_r == 3'h0 && hit)
    begin
      tx_sent_o     <= 1'b1;
      tx_sent_q_o   <= pick;
      tx_sent_len_o <= 11'h5DC;
      wait_r        <= 3'(GAP);
      ptr_r         <= pick - 2'h1;
    end
    else
    begin
      tx_sent_o     <= 1'b0;
      tx_sent_q_o   <= ~tx_sent_q_o;
      tx_sent_len_o <= ~tx_sent_len_o;
      wait_r        <= (wait_r == 3'h0) ? 3'h0 : wait_r - 3'h1;
    end
  end
endmodule : prl_tx_partner

`default_nettype wire

/* File: sim/tb_port_rate_limiter_and_queue_shaper.sv */
// self-checking bench of the port rate limiter and queue shaper
// assumes a short credit tick and the queue source model beside it
`timescale 1ns/1ps
`default_nettype none

module tb_port_rate_limiter_and_queue_shaper;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {logic [1:0] sel; logic [2:0] kind; logic drop;} prl_row_s;
  localparam prl_row_s ROWS [8] = '{'{2'h0, 3'h4, 1'b1}, '{2'h0, 3'h0, 1'b1},
    '{2'h1, 3'h4, 1'b1}, '{2'h1, 3'h2, 1'b0}, '{2'h2, 3'h2, 1'b1},
    '{2'h2, 3'h1, 1'b0}, '{2'h3, 3'h1, 1'b1}, '{2'h3, 3'h4, 1'b0}};
  localparam logic [39:0] REGS [7] = '{40'h10_0804_0201, 40'h14_0000_FA50,
    40'h18_0000_0000, 40'h1C_5555_5555, 40'h20_AAAA_AAAA, 40'h24_FFFF_FFFF,
    40'h30_0000_0000};
  localparam logic [11:0] PRIO [5] = '{12'h623, 12'h82A, 12'h825, 12'h611, 12'h010};
  localparam logic [31:0] RAT [2] = '{32'h0804_0201, 32'h0401_0101};
  logic        clk, rst_n, wr, rd, spd10, rvld, rmc, rbc, rfl, rtag, rip, mfull;
  logic        dvld, ddrop, pause, tsent;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seen, r3;
  logic [2:0]  pcp;
  logic [5:0]  dscp;
  logic [10:0] rlen, tlen;
  logic [1:0]  dq, tq;
  logic [3:0]  pend, pend_en, ok;
  int          failures, samples_checked;
  int          cnt [4];

  prl_port_shaper #(.TICK_CYC(50), .LEN_W(11)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .speed10_i(spd10), .rx_vld_i(rvld), .rx_len_i(rlen),
    .rx_mc_i(rmc), .rx_bc_i(rbc), .rx_flood_i(rfl), .rx_tag_i(rtag), .rx_pcp_i(pcp),
    .rx_ip_i(rip), .rx_dscp_i(dscp), .rx_mem_full_i(mfull), .rx_dec_vld_o(dvld),
    .rx_dec_drop_o(ddrop), .rx_dec_q_o(dq), .rx_pause_o(pause), .tx_pend_i(pend),
    .tx_sent_i(tsent), .tx_sent_q_i(tq), .tx_sent_len_i(tlen), .tx_ok_o(ok));

  prl_tx_partner #(.GAP(3)) u_src (.clk_i(clk), .rst_n_i(rst_n), .pend_en_i(pend_en),
    .tx_ok_i(ok), .tx_pend_o(pend), .tx_sent_o(tsent), .tx_sent_q_o(tq),
    .tx_sent_len_o(tlen));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    seen = rdata;
  endtask : rreg

  task automatic rx(input logic [2:0] kind);
    @(posedge clk);
    rvld <= 1'b1;
    {rmc, rbc, rfl} <= kind;
    @(posedge clk);
    rvld <= 1'b0;
    #1;
    chk("rx_dec_vld", 32'h1, 32'(dvld));
  endtask : rx

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // clock, counting, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
    if (tsent === 1'b1)
      cnt[tq]++;

  initial
  begin
    #(4 * 20000);
    failures++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, wr, rd, spd10, rvld, rmc, rbc, rfl, rtag, rip, mfull} = '0;
    {addr, wdata, pend_en, failures, samples_checked} = '0;
    rlen = 11'h5DC;
    pcp  = 3'h5;
    dscp = 6'h1A;
    foreach (cnt[k]) cnt[k] = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("tx_ok in reset", 32'h0, 32'(ok));
    @(posedge clk);
    #1;
    chk("tx_ok after reset", 32'h1, 32'(ok));
    foreach (REGS[i])
    begin
      rreg(REGS[i][39:32]);
      chk("reg reset value", REGS[i][31:0], seen);
    end
    @(posedge clk);
    #1;
    chk("rdata one cycle", 32'h0, rdata);
    wreg(8'h30, 32'hFFFF_FFFF);
    rreg(8'h30);
    chk("unmapped read", 32'h0, seen);
    $display("reset and register test done");
    wreg(prl_pkg::ADR_IRATE, 32'h0000_0065);
    foreach (ROWS[i])
    begin
      wreg(prl_pkg::ADR_PCTL, 32'({ROWS[i].sel, 2'h0}));
      repeat (8) rx((ROWS[i].sel == 2'h0) ? 3'h0 : 3'(3'h1 << (3 - ROWS[i].sel)));
      rx(ROWS[i].kind);
      chk("rx_dec_drop", 32'(ROWS[i].drop), 32'(ddrop));
    end
    $display("frame select test done");
    wreg(prl_pkg::ADR_PCTL, 32'h0000_0010);
    rx(3'h0);
    chk("drop under pause", 32'h0, 32'(ddrop));
    @(posedge clk);
    #1;
    chk("rx_pause", 32'h1, 32'(pause));
    wreg(prl_pkg::ADR_PCTL, 32'h0);
    wreg(prl_pkg::ADR_IRATE, 32'h0);
    mfull <= 1'b1;
    rx(3'h0);
    chk("drop memory full", 32'h1, 32'(ddrop));
    mfull <= 1'b0;
    rx(3'h0);
    chk("drop unlimited", 32'h0, 32'(ddrop));
    wreg(prl_pkg::ADR_IRATE, 32'h0000_0032);
    spd10 <= 1'b1;
    repeat (9) rx(3'h0);
    chk("drop at 10M", 32'h0, 32'(ddrop));
    spd10 <= 1'b0;
    repeat (9) rx(3'h0);
    chk("drop at 100M", 32'h1, 32'(ddrop));
    rreg(prl_pkg::ADR_STAT);
    chk("drop count", 32'h0000_004D, 32'(seen[31:16]));
    rlen <= 11'h001;
    for (int g = 0; g < 8; g += 6)
    begin
      wreg(prl_pkg::ADR_IRATE, 32'h0);
      wreg(prl_pkg::ADR_GLB, 32'(g));
      wreg(prl_pkg::ADR_IRATE, 32'h0000_0065);
      rx(3'h0);
      repeat (100) @(posedge clk);
      rx(3'h0);
      chk("drop gap bytes", 32'(g > 0), 32'(ddrop));
    end
    rlen <= 11'h5DC;
    $display("policing test done");
    wreg(prl_pkg::ADR_GLB, 32'h1);
    wreg(prl_pkg::ADR_IRATE, 32'h0);
    foreach (PRIO[i])
    begin
      wreg(prl_pkg::ADR_PCTL, 32'(PRIO[i][11:4]));
      rtag <= PRIO[i][3];
      rip  <= PRIO[i][2];
      rx(3'h0);
      chk("rx_dec_q", 32'(PRIO[i][1:0]), 32'(dq));
    end
    $display("priority test done");
    foreach (RAT[i])
    begin
      wreg(prl_pkg::ADR_RATIO, RAT[i]);
      wreg(prl_pkg::ADR_PCTL, 32'h2);
      wreg(prl_pkg::ADR_ERATE, 32'h0);
      foreach (cnt[k]) cnt[k] = 0;
      pend_en <= 4'hF;
      repeat (600)
      begin
        @(posedge clk);
        #1;
        chk("tx_ok top queue", 32'h1, 32'(ok[3]));
      end
      pend_en <= 4'h0;
      repeat (8) @(posedge clk);
      r3 = 32'(RAT[i][30:24]);
      chk("q0 served", 32'h1, 32'(cnt[0] > 0));
      chk("q3 share", 32'h1, 32'(cnt[3] <= r3 * (cnt[0] + 1) && cnt[3] + r3 >= r3 * cnt[0]));
    end
    $display("ratio test done");
    wreg(prl_pkg::ADR_GLB, 32'h0);
    wreg(prl_pkg::ADR_PCTL, 32'h0);
    wreg(prl_pkg::ADR_ERATE, 32'h0000_0065);
    foreach (cnt[k]) cnt[k] = 0;
    pend_en <= 4'h1;
    repeat (400) @(posedge clk);
    #1;
    chk("q0 shaped", 32'h1, 32'(cnt[0] >= 1 && cnt[0] <= 7));
    chk("tx_ok q0 held", 32'h0, 32'(ok[0]));
    chk("tx_ok upper", 32'h0, 32'(ok[3:1]));
    pend_en <= 4'h0;
    $display("shaping test done");
    wrap_up();
  end
endmodule : tb_port_rate_limiter_and_queue_shaper

`default_nettype wire
